// File: design/dtcu_pkg.sv
/*
 * Package for the dual timer/counter unit: register map, field layout,
 * reset values and machine-cycle timing.
 * Assumes an AXI4-Lite master with 32-bit data and one clock domain.
 */
package dtcu_pkg;

	// ---------------------------------------------------------------
	// Register byte offsets
	// ---------------------------------------------------------------
	localparam logic [3:0] DTCU_OFF_CTRL  = 4'h0;
	localparam logic [3:0] DTCU_OFF_MODE  = 4'h4;
	localparam logic [3:0] DTCU_OFF_CH0   = 4'h8;
	localparam logic [3:0] DTCU_OFF_CH1   = 4'hc;

	// ---------------------------------------------------------------
	// Control register bit positions
	// ---------------------------------------------------------------
	localparam int DTCU_CTL_OVF1 = 7;
	localparam int DTCU_CTL_RUN1 = 6;
	localparam int DTCU_CTL_OVF0 = 5;
	localparam int DTCU_CTL_RUN0 = 4;
	localparam int DTCU_CTL_EDG1 = 3;
	localparam int DTCU_CTL_TYP1 = 2;
	localparam int DTCU_CTL_EDG0 = 1;
	localparam int DTCU_CTL_TYP0 = 0;

	// ---------------------------------------------------------------
	// Mode nibble layout (channel 1 at bit 4, channel 0 at bit 0)
	// ---------------------------------------------------------------
	localparam int DTCU_NIB_CH1 = 4;
	localparam int DTCU_NIB_CH0 = 0;
	localparam int DTCU_MF_GATE = 3;
	localparam int DTCU_MF_FUNC = 2;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0]  DTCU_RST_CTRL  = 8'h00;
	localparam logic [7:0]  DTCU_RST_MODE  = 8'h00;
	localparam logic [15:0] DTCU_RST_COUNT = 16'h0000;

	// ---------------------------------------------------------------
	// Timing: machine cycle = 6 CPU periods = 12 oscillator periods
	// ---------------------------------------------------------------
	localparam int DTCU_CPU_PER_MC = 6;
	localparam int DTCU_OSC_PER_MC = 2 * DTCU_CPU_PER_MC;
	localparam logic [3:0] DTCU_PH_SAMPLE = 4'h9;
	localparam logic [3:0] DTCU_PH_UPDATE = 4'h4;

	typedef enum logic [1:0] {
		DTCU_M13,
		DTCU_M16,
		DTCU_M8R,
		DTCU_MSPLIT
	} dtcu_mode_t;

	typedef struct packed {
		logic       gate;
		logic       func;
		dtcu_mode_t mode;
	} dtcu_cfg_t;

	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} dtcu_cnt_t;

endpackage

// File: design/dtcu_top.sv
/*
 * Dual timer/counter unit with AXI4-Lite register access.
 * Assumes aclk is the oscillator clock; pins are asynchronous and are
 * synchronised here. Interrupt acknowledge arrives as one-cycle pulses.
 */
`timescale 1ns/100ps
`default_nettype none

module dtcu_top
	import dtcu_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// External pins
	input  wire logic        ch0_count_pin,
	input  wire logic        ch1_count_pin,
	input  wire logic        ext_irq0_pin,
	input  wire logic        ext_irq1_pin,
	// Interrupt vector acknowledges
	input  wire logic        ack_ch0_ovf,
	input  wire logic        ack_ch1_ovf,
	input  wire logic        ack_irq0,
	input  wire logic        ack_irq1,
	// Flag outputs
	output logic             ch0_overflow_flag,
	output logic             ch1_overflow_flag,
	output logic             ext_irq0_req,
	output logic             ext_irq1_req
);

	// -----------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------
	logic [7:0]  timer_control_flags;
	logic [7:0]  timer_mode_select;
	dtcu_cnt_t   cnt0;
	dtcu_cnt_t   cnt1;
	logic [3:0]  phase;
	logic [3:0]  sync_a;
	logic [3:0]  sync_b;
	logic [1:0]  samp;
	logic [1:0]  samp_prev;
	logic [1:0]  edge_pend;
	logic [1:0]  irq_prev;

	dtcu_cfg_t   cfg0;
	dtcu_cfg_t   cfg1;
	logic        mc_tick;
	logic        upd_tick;
	logic        pin0;
	logic        pin1;
	logic        irq0;
	logic        irq1;
	logic        en0;
	logic        en1;
	logic        en0h;
	logic        inc0;
	logic        inc1;
	logic        inc0h;
	logic        ovf0;
	logic        ovf1;
	dtcu_cnt_t   next_cnt0;
	dtcu_cnt_t   next_cnt1;

	assign cfg0 = dtcu_cfg_t'(timer_mode_select[DTCU_NIB_CH0 +: 4]);
	assign cfg1 = dtcu_cfg_t'(timer_mode_select[DTCU_NIB_CH1 +: 4]);
	assign pin0 = sync_b[0];
	assign pin1 = sync_b[1];
	assign irq0 = sync_b[2];
	assign irq1 = sync_b[3];

	// -----------------------------------------------------------------
	// Machine cycle phase
	// -----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase <= 4'h0;
		end else if (phase == 4'(DTCU_OSC_PER_MC - 1)) begin
			phase <= 4'h0;
		end else begin
			phase <= phase + 4'h1;
		end
	end
	assign mc_tick  = (phase == DTCU_PH_SAMPLE);
	assign upd_tick = (phase == DTCU_PH_UPDATE);

	// -----------------------------------------------------------------
	// Pin synchronisers
	// -----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_a <= 4'h0;
			sync_b <= 4'h0;
		end else begin
			sync_a <= {ext_irq1_pin, ext_irq0_pin, ch1_count_pin, ch0_count_pin};
			sync_b <= sync_a;
		end
	end

	// -----------------------------------------------------------------
	// Count pin sampling and edge detection
	// -----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			samp      <= 2'h0;
			samp_prev <= 2'h0;
		end else if (mc_tick) begin
			samp      <= {pin1, pin0};
			samp_prev <= samp;
		end
	end
	// Edge from the last two samples, counted at the next update phase
	assign edge_pend = samp_prev & ~samp;

	// -----------------------------------------------------------------
	// Enables and increments
	// -----------------------------------------------------------------
	// Count on update phase, timer every cycle, counter only on edge
	assign en0  = timer_control_flags[DTCU_CTL_RUN0]
		&& (!cfg0.gate || irq0);
	// Split channel 0 takes the run bit; channel 1 then runs by mode
	assign en1  = (timer_control_flags[DTCU_CTL_RUN1]
		|| cfg0.mode == DTCU_MSPLIT)
		&& (!cfg1.gate || irq1)
		&& (cfg1.mode != DTCU_MSPLIT);
	assign en0h = timer_control_flags[DTCU_CTL_RUN1];
	assign inc0 = upd_tick && en0
		&& (cfg0.func ? edge_pend[0] : 1'b1);
	assign inc1 = upd_tick && en1 && (cfg1.func ? edge_pend[1] : 1'b1);
	assign inc0h = upd_tick && en0h && (cfg0.mode == DTCU_MSPLIT);

	// Shared next-value logic per channel
	function automatic logic [16:0] dtcu_step(input dtcu_cnt_t c,
		input dtcu_mode_t m);
		logic [16:0] r;
		r = {1'b0, c};
		case (m)
			DTCU_M13: begin
				if (c.lo[4:0] == 5'h1f) begin
					r[4:0]  = 5'h00;
					r[15:8] = c.hi + 8'h01;
					r[16]   = (c.hi == 8'hff);
				end else begin
					r[4:0] = c.lo[4:0] + 5'h01;
				end
			end
			DTCU_M16: begin
				r = {1'b0, c} + 17'h00001;
			end
			default: begin
				if (c.lo == 8'hff) begin
					r[7:0] = c.hi;
					r[16]  = 1'b1;
				end else begin
					r[7:0] = c.lo + 8'h01;
				end
			end
		endcase
		return r;
	endfunction

	always_comb begin
		logic [16:0] s0;
		logic [16:0] s1;
		s0 = dtcu_step(cnt0, cfg0.mode);
		s1 = dtcu_step(cnt1, cfg1.mode);
		next_cnt0 = cnt0;
		next_cnt1 = cnt1;
		ovf0 = 1'b0;
		ovf1 = 1'b0;
		if (cfg0.mode == DTCU_MSPLIT) begin
			if (inc0) begin
				next_cnt0.lo = cnt0.lo + 8'h01;
				ovf0 = (cnt0.lo == 8'hff);
			end
			if (inc0h) begin
				next_cnt0.hi = cnt0.hi + 8'h01;
				ovf1 = (cnt0.hi == 8'hff);
			end
		end else if (inc0) begin
			next_cnt0 = dtcu_cnt_t'(s0[15:0]);
			ovf0 = s0[16];
		end
		if (inc1) begin
			next_cnt1 = dtcu_cnt_t'(s1[15:0]);
			if (cfg0.mode != DTCU_MSPLIT) begin
				ovf1 = s1[16];
			end
		end
	end

	// -----------------------------------------------------------------
	// AXI4-Lite slave handshake
	// -----------------------------------------------------------------
	logic        aw_held;
	logic        w_held;
	logic [3:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        do_wr;

	assign do_wr = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 4'h0;
			w_data        <= 32'h0;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr == DTCU_OFF_CTRL || aw_addr == DTCU_OFF_MODE
					|| aw_addr == DTCU_OFF_CH0 || aw_addr == DTCU_OFF_CH1) begin
					s_axi_bresp <= 2'h0;
				end else begin
					s_axi_bresp <= 2'h2;
				end
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'h0;
				if (s_axi_araddr == DTCU_OFF_CTRL) begin
					s_axi_rdata <= {24'h0, timer_control_flags};
				end else if (s_axi_araddr == DTCU_OFF_MODE) begin
					s_axi_rdata <= {24'h0, timer_mode_select};
				end else if (s_axi_araddr == DTCU_OFF_CH0) begin
					s_axi_rdata <= {16'h0, cnt0};
				end else if (s_axi_araddr == DTCU_OFF_CH1) begin
					s_axi_rdata <= {16'h0, cnt1};
				end else begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= 2'h2;
				end
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// -----------------------------------------------------------------
	// Mode register and counts
	// -----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_mode_select <= DTCU_RST_MODE;
		end else if (do_wr && aw_addr == DTCU_OFF_MODE && w_strb[0]) begin
			timer_mode_select <= w_data[7:0];
		end
	end

	// Software write wins over a count in the same cycle; run bit
	// changes never touch the counts
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt0 <= DTCU_RST_COUNT;
			cnt1 <= DTCU_RST_COUNT;
		end else begin
			cnt0 <= next_cnt0;
			cnt1 <= next_cnt1;
			if (do_wr && aw_addr == DTCU_OFF_CH0) begin
				if (w_strb[0]) cnt0.lo <= w_data[7:0];
				if (w_strb[1]) cnt0.hi <= w_data[15:8];
			end
			if (do_wr && aw_addr == DTCU_OFF_CH1) begin
				if (w_strb[0]) cnt1.lo <= w_data[7:0];
				if (w_strb[1]) cnt1.hi <= w_data[15:8];
			end
		end
	end

	// -----------------------------------------------------------------
	// Control flags: overflow, edge, run and type bits
	// -----------------------------------------------------------------
	logic wr_ctl;
	logic [7:0] hw_set;
	logic [7:0] hw_clr;
	assign wr_ctl = do_wr && aw_addr == DTCU_OFF_CTRL && w_strb[0];

	always_comb begin
		hw_set = 8'h00;
		hw_clr = 8'h00;
		hw_set[DTCU_CTL_OVF0] = ovf0;
		hw_set[DTCU_CTL_OVF1] = ovf1;
		hw_clr[DTCU_CTL_OVF0] = ack_ch0_ovf;
		hw_clr[DTCU_CTL_OVF1] = ack_ch1_ovf;
		// Falling edge or low level per type bit
		hw_set[DTCU_CTL_EDG0] = timer_control_flags[DTCU_CTL_TYP0]
			? (irq_prev[0] && !irq0) : !irq0;
		hw_set[DTCU_CTL_EDG1] = timer_control_flags[DTCU_CTL_TYP1]
			? (irq_prev[1] && !irq1) : !irq1;
		hw_clr[DTCU_CTL_EDG0] = ack_irq0;
		hw_clr[DTCU_CTL_EDG1] = ack_irq1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_control_flags <= DTCU_RST_CTRL;
			irq_prev            <= 2'h0;
		end else begin
			irq_prev <= {irq1, irq0};
			// Set beats software write and acknowledge
			timer_control_flags <= ((wr_ctl ? w_data[7:0]
				: timer_control_flags) & ~hw_clr) | hw_set;
		end
	end

	// -----------------------------------------------------------------
	// Flag outputs
	// -----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ch0_overflow_flag <= 1'b0;
			ch1_overflow_flag <= 1'b0;
			ext_irq0_req      <= 1'b0;
			ext_irq1_req      <= 1'b0;
		end else begin
			ch0_overflow_flag <= timer_control_flags[DTCU_CTL_OVF0];
			ch1_overflow_flag <= timer_control_flags[DTCU_CTL_OVF1];
			ext_irq0_req      <= timer_control_flags[DTCU_CTL_EDG0];
			ext_irq1_req      <= timer_control_flags[DTCU_CTL_EDG1];
		end
	end

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	stop_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!timer_control_flags[DTCU_CTL_RUN0] && !do_wr)
		|=> cnt0.lo == $past(cnt0.lo))
		else $error("channel 0 low byte moved while stopped");
	mc_rate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		inc1 |=> !inc1 [*8])
		else $error("channel 1 counted twice in a machine cycle");
	split_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(cfg1.mode == DTCU_MSPLIT && !do_wr) |=> cnt1 == $past(cnt1))
		else $error("channel 1 moved in mode 3");
	reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(inc0 && cfg0.mode == DTCU_M8R && cnt0.lo == 8'hff && !do_wr)
		|=> cnt0.lo == $past(cnt0.hi))
		else $error("mode 2 reload missing");
	ovf_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ovf0 |=> timer_control_flags[DTCU_CTL_OVF0])
		else $error("overflow flag not set");
	ovf_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ovf1 |=> ##1 ch1_overflow_flag)
		else $error("channel 1 flag output late");
	edge_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(timer_control_flags[DTCU_CTL_TYP0] && irq_prev[0] && !irq0)
		|=> timer_control_flags[DTCU_CTL_EDG0])
		else $error("edge flag not set");
	upd_phase_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(phase != DTCU_PH_UPDATE && !do_wr)
		|=> (cnt0 == $past(cnt0) && cnt1 == $past(cnt1)))
		else $error("count outside update phase");

endmodule // dtcu_top

`default_nettype wire

// File: verif/dtcu_pin_model.sv
/*
 * Model of the external count and gate/interrupt pins of the timer unit.
 * Assumes the bench calls its tasks; pins change just after aclk rises.
 */
`timescale 1ns/100ps
`default_nettype none

module dtcu_pin_model (
	// Clock
	input  wire logic aclk,
	// Pins toward the block
	output logic      ch0_count_pin,
	output logic      ch1_count_pin,
	output logic      ext_irq0_pin,
	output logic      ext_irq1_pin
);
	// ---------------------------------------------------------------
	// Pin drivers
	// ---------------------------------------------------------------
	initial begin
		ch0_count_pin = 1'b1;
		ch1_count_pin = 1'b1;
		ext_irq0_pin  = 1'b1;
		ext_irq1_pin  = 1'b1;
	end

	// Falling edges, each level held two machine cycles
	task automatic pulses(input logic ch, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge aclk);
			if (ch) ch1_count_pin <= 1'b0;
			else ch0_count_pin <= 1'b0;
			repeat (24) @(posedge aclk);
			if (ch) ch1_count_pin <= 1'b1;
			else ch0_count_pin <= 1'b1;
			repeat (24) @(posedge aclk);
		end
	endtask

	// Gate / interrupt pin level
	task automatic set_irq(input logic ch, input logic v);
		@(posedge aclk);
		if (ch) ext_irq1_pin <= v;
		else ext_irq0_pin <= v;
	endtask
endmodule // dtcu_pin_model

`default_nettype wire

// File: verif/dtcu_top_test.sv
/*
 * Self-checking bench for the dual timer/counter unit over AXI4-Lite.
 * Assumes the pin model drives the external pins.
 */
`timescale 1ns/100ps
`default_nettype none

module dtcu_top_test
	import dtcu_pkg::*;
;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic        aclk, aresetn;
	logic [3:0]  awaddr, araddr, ack_v;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic        cp0, cp1, ip0, ip1, ovf0, ovf1, irq0_req, irq1_req;
	int          fail_count, compares;

	dtcu_top u_dtcu_top (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ch0_count_pin(cp0), .ch1_count_pin(cp1),
		.ext_irq0_pin(ip0), .ext_irq1_pin(ip1),
		.ack_ch0_ovf(ack_v[0]), .ack_ch1_ovf(ack_v[1]),
		.ack_irq0(ack_v[2]), .ack_irq1(ack_v[3]),
		.ch0_overflow_flag(ovf0), .ch1_overflow_flag(ovf1),
		.ext_irq0_req(irq0_req), .ext_irq1_req(irq1_req)
	);

	dtcu_pin_model u_dtcu_pin_model (
		.aclk(aclk), .ch0_count_pin(cp0), .ch1_count_pin(cp1),
		.ext_irq0_pin(ip0), .ext_irq1_pin(ip1)
	);

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic check(input string n, input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic aw, w;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		forever begin
			@(posedge aclk);
			if (aw && awready) begin
				awvalid <= 1'b0;
				aw = 1'b0;
			end
			if (w && wready) begin
				wvalid <= 1'b0;
				w = 1'b0;
			end
			if (bvalid) break;
		end
		bready <= 1'b0;
		check("bresp", 32'(bresp), 32'h0);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] m, e,
			input string n);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		check(n, rdata & m, e);
	endtask

	task automatic ack(input int i);
		@(posedge aclk);
		ack_v[i] <= 1'b1;
		@(posedge aclk);
		ack_v[i] <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask

	// Load, run until overflow, then stop keeping the flag
	task automatic run_ovf(input logic [7:0] md, input logic [3:0] ca,
			input logic [15:0] cv, input logic [7:0] run, input logic ch);
		logic f;
		wr(ca, 32'(cv));
		wr(DTCU_OFF_MODE, 32'(md));
		wr(DTCU_OFF_CTRL, 32'(run));
		f = 1'b0;
		for (int i = 0; i < 600 && f !== 1'b1; i++) begin
			@(posedge aclk);
			f = ch ? ovf1 : ovf0;
		end
		wr(DTCU_OFF_CTRL, ch ? 32'h80 : 32'h20);
		check("overflow flag", 32'(f), 32'h1);
	endtask

	task automatic finish_test;
		$display("Compares %0d errors %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Clock, reset, watchdog
	// ---------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	initial begin
		repeat (40000) @(posedge aclk);
		fail_count++;
		finish_test;
	end

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		logic [31:0] d;
		aresetn = 1'b0;
		{awaddr, araddr, ack_v, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		fail_count = 0;
		compares = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		// Level flags from the cleared pin synchronisers, then reset values
		repeat (4) @(posedge aclk);
		ack(2);
		ack(3);
		rd(DTCU_OFF_CTRL, 32'hff, 32'h00, "ctrl reset");
		check("irq1 out", 32'(irq1_req), 32'h0);
		rd(DTCU_OFF_MODE, 32'hff, 32'h00, "mode reset");
		rd(DTCU_OFF_CH0, 32'hffff, 32'h0, "ch0 reset");
		rd(DTCU_OFF_CH1, 32'hffff, 32'h0, "ch1 reset");
		// Mode 1 timer from a preset count
		run_ovf(8'h01, DTCU_OFF_CH0, 16'hfffe, 8'h10, 1'b0);
		rd(DTCU_OFF_CH0, 32'hffff, 32'h0, "mode1 wrap");
		ack(0);
		check("ch0 flag out", 32'(ovf0), 32'h0);
		rd(DTCU_OFF_CTRL, 32'hff, 32'h00, "ctrl acked");
		// Mode 0, 13-bit wrap
		run_ovf(8'h00, DTCU_OFF_CH0, 16'hff1e, 8'h10, 1'b0);
		rd(DTCU_OFF_CH0, 32'hff1f, 32'h0, "mode0 wrap");
		ack(0);
		// Mode 2 reload
		run_ovf(8'h02, DTCU_OFF_CH0, 16'h80fe, 8'h10, 1'b0);
		rd(DTCU_OFF_CH0, 32'hffff, 32'h8080, "mode2 reload");
		ack(0);
		// Split mode: high byte on channel 1 controls, channel 1 held
		wr(DTCU_OFF_CH1, 32'h1234);
		run_ovf(8'h33, DTCU_OFF_CH0, 16'hff00, 8'h40, 1'b1);
		rd(DTCU_OFF_CH0, 32'hffff, 32'h0, "split ch0");
		rd(DTCU_OFF_CH1, 32'hffff, 32'h1234, "ch1 held");
		ack(1);
		check("ch1 flag out", 32'(ovf1), 32'h0);
		// Channel 1 runs by leaving mode 3 while channel 0 is split
		wr(DTCU_OFF_MODE, 32'h13);
		repeat (40) @(posedge aclk);
		wr(DTCU_OFF_MODE, 32'h33);
		rd(DTCU_OFF_CH1, 32'hffff0000, 32'h0, "ch1 free");
		d = rdata;
		check("ch1 free run", 32'(d[15:0] >= 16'h1237
			&& d[15:0] <= 16'h1238), 32'h1);
		// Channel 1 counter function on pin edges
		wr(DTCU_OFF_CH1, 32'h0);
		wr(DTCU_OFF_MODE, 32'h50);
		wr(DTCU_OFF_CTRL, 32'h40);
		u_dtcu_pin_model.pulses(1'b1, 3);
		repeat (40) @(posedge aclk);
		wr(DTCU_OFF_CTRL, 32'h00);
		rd(DTCU_OFF_CH1, 32'hffff, 32'h3, "edge count");
		// Gated timer on channel 0
		wr(DTCU_OFF_CH0, 32'h0);
		wr(DTCU_OFF_MODE, 32'h09);
		u_dtcu_pin_model.set_irq(1'b0, 1'b0);
		wr(DTCU_OFF_CTRL, 32'h10);
		repeat (60) @(posedge aclk);
		rd(DTCU_OFF_CH0, 32'hffff, 32'h0, "gate closed");
		rd(DTCU_OFF_CTRL, 32'hff, 32'h12, "level flag");
		u_dtcu_pin_model.set_irq(1'b0, 1'b1);
		repeat (60) @(posedge aclk);
		wr(DTCU_OFF_CTRL, 32'h00);
		rd(DTCU_OFF_CH0, 32'hffff0000, 32'h0, "gate read");
		d = rdata;
		check("gate open", 32'(d >= 4 && d <= 6), 32'h1);
		// Falling-edge interrupt on pin 0
		ack(2);
		wr(DTCU_OFF_CTRL, 32'h01);
		rd(DTCU_OFF_CTRL, 32'hff, 32'h01, "edge idle");
		u_dtcu_pin_model.set_irq(1'b0, 1'b0);
		repeat (30) @(posedge aclk);
		rd(DTCU_OFF_CTRL, 32'hff, 32'h03, "edge set");
		check("irq0 out", 32'(irq0_req), 32'h1);
		ack(2);
		rd(DTCU_OFF_CTRL, 32'hff, 32'h01, "edge acked");
		u_dtcu_pin_model.set_irq(1'b0, 1'b1);
		finish_test;
	end
endmodule // dtcu_top_test

`default_nettype wire
